// File: hdl/nvs_defs.svh
// Command codes, cycle counts and widths of the NVM command sequencer.
// Included by the package; plain definitions only.
`ifndef NVS_DEFS_SVH
`define NVS_DEFS_SVH

// Widths
`define NVS_CNT_W 18
`define NVS_EL_W 24
`define NVS_DIV_W 8

// Command codes
`define NVS_CMD_CHK_ALL 8'h01
`define NVS_CMD_CHK_BLK 8'h02
`define NVS_CMD_CHK_PSEC 8'h03
`define NVS_CMD_RD_ONCE 8'h04
`define NVS_CMD_PGM_P 8'h06
`define NVS_CMD_PGM_ONCE 8'h07
`define NVS_CMD_ERS_ALL 8'h08
`define NVS_CMD_ERS_PBLK 8'h09
`define NVS_CMD_ERS_PSEC 8'h0A
`define NVS_CMD_UNSECURE 8'h0B
`define NVS_CMD_KEY_VER 8'h0C
`define NVS_CMD_MRG_USER 8'h0D
`define NVS_CMD_MRG_FIELD 8'h0E
`define NVS_CMD_CHK_DSEC 8'h10
`define NVS_CMD_PGM_D 8'h11
`define NVS_CMD_ERS_DSEC 8'h12

// Operating clock window in kHz, kept by software
`define NVS_OPCLK_MIN_KHZ 800
`define NVS_OPCLK_MAX_KHZ 1050

// Bus clock counts
`define NVS_T_CHK_ALL 18'd35500
`define NVS_T_CHK_PBLK 18'd33500
`define NVS_T_CHK_DBLK 18'd2800
`define NVS_T_SEC_SETUP 18'd450
`define NVS_T_RD_ONCE 18'd400
`define NVS_T_KEY_VER 18'd400
`define NVS_T_MARGIN 18'd350
`define NVS_T_PGM_P_BUS 18'd2000
`define NVS_T_PGM_P_BUS_MAX 18'd2500
`define NVS_T_PGM_ONCE_BUS 18'd2150
`define NVS_T_ERS_ALL_BUS 18'd70000
`define NVS_T_ERS_PBLK_BUS 18'd67000
`define NVS_T_ERS_PSEC_BUS 18'd700
`define NVS_T_ERS_PSEC_BUS_MAX 18'd1400
`define NVS_T_DPGM_BUS_BASE 18'd500
`define NVS_T_DPGM_BUS_WORD 18'd525
`define NVS_T_DPGM_BUS_WORD_MAX 18'd750
`define NVS_T_DPGM_BUS_ROW 18'd100
`define NVS_T_ERS_DSEC_BUS 18'd700
`define NVS_T_ERS_DSEC_BUS_MAX 18'd3400

// Operating clock counts
`define NVS_T_PGM_OP 18'd164
`define NVS_T_ERS_ALL_OP 18'd100100
`define NVS_T_ERS_PSEC_OP 18'd20020
`define NVS_T_DPGM_OP_BASE 18'd14
`define NVS_T_DPGM_OP_WORD 18'd54
`define NVS_T_DPGM_OP_ROW 18'd14
`define NVS_T_ERS_DSEC_OP 18'd5025
`define NVS_T_ERS_DSEC_OP_MAX 18'd20100

// Array sizes in verify units
`define NVS_PFL_PHRASES 18'd16384
`define NVS_DFL_PHRASES 18'd512

`endif

// File: hdl/nvs_pkg.sv
// Types shared by the NVM command sequencer modules.
// Assumes nvs_defs.svh on the include path.
`include "nvs_defs.svh"

package nvs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SCAN = 2'b10,
    ST_OPWAIT = 2'b11
  } nvs_state_t;

  typedef struct packed {
    logic [7:0] flash_command_code;
    logic block_sel;
    logic [2:0] word_count;
    logic row_cross_flag;
    logic [15:0] section_len;
  } nvs_cmd_t;

  typedef struct packed {
    logic legal;
    logic [`NVS_CNT_W-1:0] bus;
    logic [`NVS_CNT_W-1:0] scan;
    logic [`NVS_CNT_W-1:0] op;
  } nvs_plan_t;

endpackage : nvs_pkg

// File: hdl/nvs_clk_div.sv
// Operating time base: one tick every divider+1 bus clocks.
// Assumes sys_clk is the bus clock and the divider is held steady.
`timescale 1ns/1ns
`default_nettype none
`include "nvs_defs.svh"

module nvs_clk_div #(
  parameter int DW = `NVS_DIV_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Divider setting
  input wire logic [DW-1:0] nvm_clock_divider,
  // Time base
  output logic op_tick
);

  if (DW < 2 || DW > 16) begin : g_chk
    $error("nvs_clk_div: DW out of range");
  end

  logic [DW-1:0] cnt;

  // Frequency is never checked; software owns the window
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt <= '0;
      op_tick <= 1'b0;
    end else if (cnt >= nvm_clock_divider) begin // [RULE1] [RULE2]
      cnt <= '0;
      op_tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      op_tick <= 1'b0;
    end
  end

endmodule : nvs_clk_div

`default_nettype wire

// File: hdl/nvs_blank_scan.sv
// Blank-check walker: one phrase per clock from address zero.
// Assumes arr_blank answers combinationally for the addressed phrase.
`timescale 1ns/1ns
`default_nettype none
`include "nvs_defs.svh"

module nvs_blank_scan #(
  parameter int CW = `NVS_CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic [CW-1:0] count,
  output logic done,
  output logic fail,
  // Array side
  output logic arr_rd_en,
  output logic [CW-1:0] arr_addr,
  input wire logic arr_blank
);

  logic [CW-1:0] left;
  logic last;

  assign last = !arr_blank || left == 1;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arr_rd_en <= 1'b0;
      arr_addr <= '0;
      left <= '0;
    end else if (start) begin
      arr_rd_en <= count != 0;
      arr_addr <= '0; // [RULE3]
      left <= count;
    end else if (arr_rd_en) begin
      // Stop at the first non-blank phrase
      arr_rd_en <= !last; // [RULE3]
      arr_addr <= arr_addr + 1'b1;
      left <= left - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= (start && count == 0) || (arr_rd_en && last);
      fail <= arr_rd_en && !arr_blank;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_scan_stop: assert property ( // [RULE3]
    arr_rd_en && !arr_blank |=> !arr_rd_en && done && fail)
    else $error("scan did not stop at non-blank phrase");

endmodule : nvs_blank_scan

`default_nettype wire

// File: hdl/nvs_sequencer.sv
// NVM command sequencer: times each flash command in bus clocks and
// operating clocks, runs blank checks against the array.
// Assumes one command at a time, taken while cmd_ready is high.
//
// Function
// [RULE1] Operating time base is the divided bus clock; software keeps it legal
// [RULE2] Divided clock frequency is never checked nor used to refuse commands
// [RULE3] Blank checks: setup, then one phrase per clock from zero, early stop
// [RULE4] Code 01 checks all blocks within 35500 bus cycles when blank
// [RULE5] Code 02 checks one block: 33500 program store, 2800 data store
// [RULE6] Code 03 checks program section within 450 plus one per phrase
// [RULE7] Code 04 reads the one-time field within 400 bus cycles
// [RULE8] Code 06 programs a phrase: 164 operating plus 2000, max 2500 bus
// [RULE9] Code 07 programs one-time field: 164 operating plus 2150 bus
// [RULE10] Code 08 erases all: 100100 operating plus 70000 bus cycles
// [RULE11] Code 09 erases program block: 100100 operating plus 67000 bus
// [RULE12] Code 0A erases a sector: 20020 operating plus 700, max 1400 bus
// [RULE13] Code 0B erases and unsecures: 100100 operating plus 70000 bus
// [RULE14] Code 0C verifies the backdoor key within 400 bus cycles
// [RULE15] Code 0D sets user margin level within 350 bus cycles
// [RULE16] Code 0E sets field margin level within 350 bus cycles
// [RULE17] Code 10 checks data section within 450 plus one per word
// [RULE18] Code 11 programs 1-4 data words, per-word and row-crossing terms
// [RULE19] Code 12 erases data sector: 5025 op plus 700, up to 20100/3400
// [RULE20] Completion is signalled only after the counted duration elapses; a failed blank check ends early at the non-blank phrase
`timescale 1ns/1ns
`default_nettype none
`include "nvs_defs.svh"
module nvs_sequencer #(
  parameter int DW = `NVS_DIV_W,
  parameter logic [17:0] P_CHK_ALL = `NVS_T_CHK_ALL,
  parameter logic [17:0] P_CHK_PBLK = `NVS_T_CHK_PBLK,
  parameter logic [17:0] P_ERS_ALL_BUS = `NVS_T_ERS_ALL_BUS,
  parameter logic [17:0] P_ERS_PBLK_BUS = `NVS_T_ERS_PBLK_BUS,
  parameter logic [17:0] P_ERS_ALL_OP = `NVS_T_ERS_ALL_OP,
  parameter logic [17:0] P_ERS_PSEC_OP = `NVS_T_ERS_PSEC_OP,
  parameter logic [17:0] P_ERS_DSEC_OP = `NVS_T_ERS_DSEC_OP,
  parameter logic [17:0] P_PFL_PHRASES = `NVS_PFL_PHRASES,
  parameter logic [17:0] P_DFL_PHRASES = `NVS_DFL_PHRASES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Command side
  input wire logic cmd_valid,
  input wire nvs_pkg::nvs_cmd_t cmd,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_error,
  output logic blank_fail,
  output logic busy,
  // Time base setting
  input wire logic [DW-1:0] nvm_clock_divider,
  // Array side
  output logic [7:0] arr_cmd_code,
  output logic arr_rd_en,
  output logic [17:0] arr_addr,
  input wire logic arr_blank
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (P_CHK_ALL <= P_PFL_PHRASES + P_DFL_PHRASES + 1) begin : g_chk_all
    $error("nvs_sequencer: blank-check-all count too small");
  end
  if (P_CHK_PBLK <= P_PFL_PHRASES + 1) begin : g_chk_pblk
    $error("nvs_sequencer: program block check count too small");
  end
  if (`NVS_T_CHK_DBLK <= P_DFL_PHRASES + 1) begin : g_chk_dblk
    $error("nvs_sequencer: data block check count too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  function automatic nvs_pkg::nvs_plan_t plan_of(
    input nvs_pkg::nvs_cmd_t c
  );
    nvs_pkg::nvs_plan_t p;
    logic [17:0] nw;
    logic [17:0] sl;
    p = '0;
    nw = {15'h0000, c.word_count};
    sl = {2'h0, c.section_len};
    p.legal = 1'b1;
    case (c.flash_command_code)
      `NVS_CMD_CHK_ALL: begin
        p.bus = P_CHK_ALL; // [RULE4]
        p.scan = P_PFL_PHRASES + P_DFL_PHRASES;
      end
      `NVS_CMD_CHK_BLK: begin
        p.bus = c.block_sel ? `NVS_T_CHK_DBLK : P_CHK_PBLK; // [RULE5]
        p.scan = c.block_sel ? P_DFL_PHRASES : P_PFL_PHRASES;
      end
      `NVS_CMD_CHK_PSEC, `NVS_CMD_CHK_DSEC: begin
        p.bus = `NVS_T_SEC_SETUP + sl; // [RULE6] [RULE17]
        p.scan = sl;
      end
      `NVS_CMD_RD_ONCE: p.bus = `NVS_T_RD_ONCE; // [RULE7]
      `NVS_CMD_PGM_P: begin
        p.bus = `NVS_T_PGM_P_BUS; // [RULE8]
        p.op = `NVS_T_PGM_OP;
      end
      `NVS_CMD_PGM_ONCE: begin
        p.bus = `NVS_T_PGM_ONCE_BUS; // [RULE9]
        p.op = `NVS_T_PGM_OP;
      end
      `NVS_CMD_ERS_ALL, `NVS_CMD_UNSECURE: begin
        p.bus = P_ERS_ALL_BUS; // [RULE10] [RULE13]
        p.op = P_ERS_ALL_OP;
      end
      `NVS_CMD_ERS_PBLK: begin
        p.bus = P_ERS_PBLK_BUS; // [RULE11]
        p.op = P_ERS_ALL_OP;
      end
      `NVS_CMD_ERS_PSEC: begin
        p.bus = `NVS_T_ERS_PSEC_BUS; // [RULE12]
        p.op = P_ERS_PSEC_OP;
      end
      `NVS_CMD_KEY_VER: p.bus = `NVS_T_KEY_VER; // [RULE14]
      `NVS_CMD_MRG_USER: p.bus = `NVS_T_MARGIN; // [RULE15]
      `NVS_CMD_MRG_FIELD: p.bus = `NVS_T_MARGIN; // [RULE16]
      `NVS_CMD_PGM_D: begin
        // Word count outside one to four is refused
        p.legal = nw != 0 && nw <= 18'd4; // [RULE18]
        p.bus = `NVS_T_DPGM_BUS_BASE + `NVS_T_DPGM_BUS_WORD * nw
          + (c.row_cross_flag ? `NVS_T_DPGM_BUS_ROW : 18'd0);
        p.op = `NVS_T_DPGM_OP_BASE + `NVS_T_DPGM_OP_WORD * nw
          + (c.row_cross_flag ? `NVS_T_DPGM_OP_ROW : 18'd0);
      end
      `NVS_CMD_ERS_DSEC: begin
        // New-device figure; wear-out growth is not modelled
        p.bus = `NVS_T_ERS_DSEC_BUS; // [RULE19]
        p.op = P_ERS_DSEC_OP;
      end
      default: p.legal = 1'b0;
    endcase
    return p;
  endfunction : plan_of

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  nvs_pkg::nvs_state_t state;
  nvs_pkg::nvs_plan_t plan_in;
  nvs_pkg::nvs_plan_t plan_q;
  nvs_pkg::nvs_cmd_t cmd_q;
  logic [17:0] cnt;
  logic [17:0] next_setup;
  logic [`NVS_EL_W-1:0] bus_el;
  logic [`NVS_EL_W-1:0] op_el;
  logic accept;
  logic take;
  logic setup_end;
  logic scan_start;
  logic scan_done;
  logic scan_fail;
  logic op_tick;
  logic finish;

  assign plan_in = plan_of(cmd);
  assign cmd_ready = state == nvs_pkg::ST_IDLE;
  assign busy = !cmd_ready;
  assign accept = cmd_valid && cmd_ready;
  assign take = accept && plan_in.legal;
  // Scan eats one bus clock per phrase and its result pulse one more past setup
  assign next_setup = plan_in.bus - plan_in.scan
    - {17'h00000, plan_in.scan != 0};
  assign setup_end = state == nvs_pkg::ST_SETUP && cnt == 18'd1;
  assign scan_start = setup_end && plan_q.scan != 0;
  assign finish = (setup_end && plan_q.scan == 0 && plan_q.op == 0)
    || (state == nvs_pkg::ST_SCAN && scan_done
        && (scan_fail || plan_q.op == 0))
    || (state == nvs_pkg::ST_OPWAIT && op_tick && cnt == 18'd1);

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  nvs_clk_div #(.DW(DW)) u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .nvm_clock_divider(nvm_clock_divider),
    .op_tick(op_tick)
  );

  nvs_blank_scan #(.CW(18)) u_scan (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(scan_start),
    .count(plan_q.scan),
    .done(scan_done),
    .fail(scan_fail),
    .arr_rd_en(arr_rd_en),
    .arr_addr(arr_addr),
    .arr_blank(arr_blank)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequence

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= nvs_pkg::ST_IDLE;
    end else begin
      unique case (state)
        nvs_pkg::ST_IDLE: begin
          if (take) begin // [RULE2]
            state <= nvs_pkg::ST_SETUP;
          end
        end
        nvs_pkg::ST_SETUP: begin
          if (setup_end) begin // [RULE3]
            if (plan_q.scan != 0) begin
              state <= nvs_pkg::ST_SCAN;
            end else if (plan_q.op != 0) begin
              state <= nvs_pkg::ST_OPWAIT;
            end else begin
              state <= nvs_pkg::ST_IDLE;
            end
          end
        end
        nvs_pkg::ST_SCAN: begin
          if (scan_done) begin
            state <= scan_fail || plan_q.op == 0 ?
              nvs_pkg::ST_IDLE : nvs_pkg::ST_OPWAIT;
          end
        end
        nvs_pkg::ST_OPWAIT: begin
          if (finish) begin
            state <= nvs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Bus clocks in setup, operating ticks in the wait
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (take) begin
      cnt <= next_setup; // [RULE20]
    end else if (setup_end) begin
      cnt <= plan_q.op;
    end else if (state == nvs_pkg::ST_SETUP) begin
      cnt <= cnt - 1'b1;
    end else if (state == nvs_pkg::ST_OPWAIT && op_tick) begin
      cnt <= cnt - 1'b1; // [RULE20]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      plan_q <= '0;
      cmd_q <= '0;
      arr_cmd_code <= 8'h00;
    end else if (take) begin
      plan_q <= plan_in;
      cmd_q <= cmd;
      arr_cmd_code <= cmd.flash_command_code;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      blank_fail <= 1'b0;
    end else begin
      cmd_done <= finish; // [RULE20]
      cmd_error <= accept && !plan_in.legal;
      if (state == nvs_pkg::ST_SCAN && scan_done && scan_fail) begin
        blank_fail <= 1'b1; // [RULE3]
      end else if (take) begin
        blank_fail <= 1'b0;
      end
    end
  end

  // Elapsed counts, read by the checks below
  always_ff @(posedge sys_clk) begin
    if (srst || take) begin
      bus_el <= '0;
      op_el <= '0;
    end else begin
      if (state == nvs_pkg::ST_SETUP || state == nvs_pkg::ST_SCAN) begin
        bus_el <= bus_el + 1'b1;
      end
      if (state == nvs_pkg::ST_OPWAIT && op_tick) begin
        op_el <= op_el + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_done_counts: assert property ( // [RULE20]
    cmd_done && !blank_fail |->
      bus_el == plan_q.bus && op_el == plan_q.op)
    else $error("done before counted duration");

  a_freq_unchecked: assert property ( // [RULE2]
    take |=> busy && !cmd_error)
    else $error("legal command not started");

  a_illegal_reject: assert property ( // [RULE18]
    accept && !plan_in.legal |=> cmd_error && !busy)
    else $error("illegal command not refused");

  a_scan_zero: assert property ( // [RULE3]
    $rose(arr_rd_en) |-> arr_addr == 18'h00000)
    else $error("scan did not start at zero");

  a_scan_step: assert property ( // [RULE3]
    arr_rd_en && $past(arr_rd_en) |->
      arr_addr == $past(arr_addr) + 18'h00001)
    else $error("scan skipped a phrase");

  a_blank_early: assert property ( // [RULE3]
    arr_rd_en && !arr_blank |=> ##1 cmd_done && blank_fail)
    else $error("no early finish on non-blank");

  a_chk_all_time: assert property ( // [RULE4]
    cmd_done && arr_cmd_code == `NVS_CMD_CHK_ALL |->
      bus_el <= P_CHK_ALL)
    else $error("check all too long");

  a_dblk_time: assert property ( // [RULE5]
    cmd_done && arr_cmd_code == `NVS_CMD_CHK_BLK && cmd_q.block_sel |->
      bus_el <= `NVS_T_CHK_DBLK)
    else $error("data block check too long");

  a_sect_time: assert property ( // [RULE6] [RULE17]
    cmd_done && (arr_cmd_code == `NVS_CMD_CHK_PSEC
      || arr_cmd_code == `NVS_CMD_CHK_DSEC) |->
      bus_el <= `NVS_T_SEC_SETUP + cmd_q.section_len)
    else $error("section check too long");

  a_short_cmds: assert property ( // [RULE15] [RULE16]
    cmd_done && (arr_cmd_code == `NVS_CMD_MRG_USER
      || arr_cmd_code == `NVS_CMD_MRG_FIELD) |->
      bus_el <= `NVS_T_MARGIN && op_el == 0)
    else $error("margin set too long");

  a_pgm_p_max: assert property ( // [RULE8]
    cmd_done && arr_cmd_code == `NVS_CMD_PGM_P |->
      bus_el <= `NVS_T_PGM_P_BUS_MAX && op_el == `NVS_T_PGM_OP)
    else $error("phrase program out of bound");

  a_psec_max: assert property ( // [RULE12]
    cmd_done && arr_cmd_code == `NVS_CMD_ERS_PSEC |->
      bus_el <= `NVS_T_ERS_PSEC_BUS_MAX && op_el == P_ERS_PSEC_OP)
    else $error("sector erase out of bound");

  a_dpgm_max: assert property ( // [RULE18]
    cmd_done && arr_cmd_code == `NVS_CMD_PGM_D |->
      bus_el <= `NVS_T_DPGM_BUS_BASE
        + `NVS_T_DPGM_BUS_WORD_MAX * cmd_q.word_count
        + (cmd_q.row_cross_flag ? `NVS_T_DPGM_BUS_ROW : 18'd0))
    else $error("data program bus time out of bound");

  a_dsec_max: assert property ( // [RULE19]
    cmd_done && arr_cmd_code == `NVS_CMD_ERS_DSEC |->
      bus_el <= `NVS_T_ERS_DSEC_BUS_MAX
        && op_el <= `NVS_T_ERS_DSEC_OP_MAX)
    else $error("data sector erase out of bound");

  c_blank_pass: cover property (
    cmd_done && !blank_fail && arr_cmd_code == `NVS_CMD_CHK_BLK);
  c_blank_fail: cover property (cmd_done && blank_fail);
  c_dpgm_row: cover property (
    cmd_done && arr_cmd_code == `NVS_CMD_PGM_D && cmd_q.row_cross_flag);
  c_illegal: cover property (cmd_error);

endmodule : nvs_sequencer

`default_nettype wire

// File: tb/nvs_array_model.sv
// Array model behind the sequencer: answers blank per addressed phrase.
// Assumes the bench sets fail_en and fail_addr only while idle.
`timescale 1ns/1ns
`default_nettype none

module nvs_array_model (
  // Clock
  input wire logic sys_clk,
  // Read side
  input wire logic arr_rd_en,
  input wire logic [17:0] arr_addr,
  output logic arr_blank,
  // Fault setting
  input wire logic fail_en,
  input wire logic [17:0] fail_addr
);
  logic idle_pat = 1'b0;

  // Toggles so an unread answer never looks settled
  always_ff @(posedge sys_clk) begin
    idle_pat <= !idle_pat;
  end

  always_comb begin
    if (arr_rd_en) begin
      arr_blank = !(fail_en && arr_addr == fail_addr);
    end else begin
      arr_blank = idle_pat;
    end
  end
endmodule : nvs_array_model

`default_nettype wire

// File: tb/tb_nvs_sequencer.sv
// Self-checking bench of the NVM command sequencer with short counts.
// Assumes the sequencer's hand-over timing and the array model beside it.
`timescale 1ns/1ns
`default_nettype none

`define CHECK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD %0t %s", $time, m); end end

module tb_nvs_sequencer;
  localparam int L_ALL = 600;
  localparam int L_PBLK = 500;
  localparam int L_EA_B = 300;
  localparam int L_EP_B = 280;
  localparam int L_EA_O = 20;
  localparam int L_PS_O = 10;
  localparam int L_DS_O = 8;
  localparam int L_PFL = 64;
  localparam int L_DFL = 16;
  typedef struct {
    bit err;
    logic bf;
    logic [7:0] code;
    int t;
    int lo;
    int hi;
  } nvs_note_t;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  nvs_pkg::nvs_cmd_t cmd = '0;
  logic [7:0] nvm_clock_divider = 8'h01;
  logic fail_en = 1'b0;
  logic [17:0] fail_addr = 18'h0;
  logic cmd_ready, cmd_done, cmd_error, blank_fail, busy, arr_rd_en, arr_blank;
  logic [7:0] arr_cmd_code;
  logic [17:0] arr_addr;
  int cyc = 0;
  int div = 1;
  int miscompares = 0;
  int checks_done = 0;
  int unsigned seed = 81;
  logic rd_q = 1'b0;
  nvs_note_t q[$];
  byte unsigned codes[17] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h04, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11,
    8'h12};

  nvs_sequencer #(.P_CHK_ALL(18'(L_ALL)), .P_CHK_PBLK(18'(L_PBLK)),
    .P_ERS_ALL_BUS(18'(L_EA_B)), .P_ERS_PBLK_BUS(18'(L_EP_B)),
    .P_ERS_ALL_OP(18'(L_EA_O)), .P_ERS_PSEC_OP(18'(L_PS_O)),
    .P_ERS_DSEC_OP(18'(L_DS_O)), .P_PFL_PHRASES(18'(L_PFL)),
    .P_DFL_PHRASES(18'(L_DFL))) dut (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .blank_fail(blank_fail), .busy(busy),
    .nvm_clock_divider(nvm_clock_divider), .arr_cmd_code(arr_cmd_code),
    .arr_rd_en(arr_rd_en), .arr_addr(arr_addr), .arr_blank(arr_blank));

  nvs_array_model arr (.sys_clk(sys_clk), .arr_rd_en(arr_rd_en),
    .arr_addr(arr_addr), .arr_blank(arr_blank), .fail_en(fail_en),
    .fail_addr(fail_addr));

  initial begin
    forever #10 sys_clk = !sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic int unsigned nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  // Bus count, operating ticks and scan length of a command
  function automatic void plan(input nvs_pkg::nvs_cmd_t c, output int bus,
                               output int op, output int n, output bit ok);
    int w;
    w = int'(c.word_count);
    bus = 0;
    op = 0;
    n = 0;
    ok = 1'b1;
    case (c.flash_command_code)
      8'h01: begin bus = L_ALL; n = L_PFL + L_DFL; end
      8'h02: begin bus = c.block_sel ? 2800 : L_PBLK;
        n = c.block_sel ? L_DFL : L_PFL; end
      8'h03, 8'h10: begin n = int'(c.section_len); bus = 450 + n; end
      8'h04, 8'h0C: bus = 400;
      8'h0D, 8'h0E: bus = 350;
      8'h06: begin bus = 2000; op = 164; end
      8'h07: begin bus = 2150; op = 164; end
      8'h08, 8'h0B: begin bus = L_EA_B; op = L_EA_O; end
      8'h09: begin bus = L_EP_B; op = L_EA_O; end
      8'h0A: begin bus = 700; op = L_PS_O; end
      8'h11: begin ok = (w >= 1 && w <= 4);
        bus = 500 + 525 * w + 100 * int'(c.row_cross_flag);
        op = 14 + 54 * w + 14 * int'(c.row_cross_flag); end
      8'h12: begin bus = 700; op = L_DS_O; end
      default: ok = 1'b0;
    endcase
  endfunction : plan

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Holds the request until taken; k is the failing phrase or -1
  task automatic run(input nvs_pkg::nvs_cmd_t c, input int k);
    nvs_note_t nt;
    int bus, op, n, i;
    bit ok, r, got;
    plan(c, bus, op, n, ok);
    nt.err = !ok;
    nt.bf = (k >= 0);
    nt.code = c.flash_command_code;
    // Refusal pulse stands in the cycle right after the taking edge
    nt.lo = ok ? bus : 0;
    nt.hi = nt.lo;
    if (ok && k >= 0) begin
      nt.lo = bus - n + k + 1;
      nt.hi = nt.lo;
    end else if (ok && op > 0) begin
      nt.lo = bus + (op - 1) * (div + 1);
      nt.hi = bus + op * (div + 1) + 1;
    end
    got = 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    for (i = 0; i < 10000 && !got; i++) begin
      @(negedge sys_clk);
      r = cmd_ready;
      @(posedge sys_clk);
      got = r;
    end
    nt.t = cyc;
    q.push_back(nt);
    cmd_valid <= 1'b0;
    if (!got) begin
      miscompares++;
      $display("BAD %0t command never taken", $time);
      print_verdict();
    end
  endtask : run

  task automatic wait_idle();
    int i;
    for (i = 0; i < 10000 && q.size() != 0; i++) @(posedge sys_clk);
    if (q.size() != 0) begin
      miscompares++;
      $display("BAD %0t result never came", $time);
      print_verdict();
    end
  endtask : wait_idle

  task automatic mk(input byte unsigned code, input int k, input bit bs,
                    input int len, input int wc);
    nvs_pkg::nvs_cmd_t c;
    c = '0;
    c.flash_command_code = code;
    c.block_sel = bs;
    c.word_count = 3'(wc);
    c.row_cross_flag = 1'(nxt() % 2);
    c.section_len = 16'(len);
    run(c, k);
  endtask : mk

  //////////////////////////////////////////////////////////////////////////
  // Result watcher: pops the oldest note on each done or error pulse
  always @(negedge sys_clk) begin
    nvs_note_t n;
    int el;
    if (!srst) begin
      if (arr_rd_en === 1'b1 && !rd_q)
        `CHECK(arr_addr, 18'h0, "scan start")
      rd_q = arr_rd_en;
      if (cmd_done === 1'b1 || cmd_error === 1'b1) begin
        if (q.size() == 0) begin
          miscompares++;
          $display("BAD %0t result without request", $time);
        end else begin
          n = q.pop_front();
          el = cyc - n.t - 1;
          `CHECK(cmd_error, n.err, "result kind")
          `CHECK(el >= n.lo && el <= n.hi, 1'b1, "duration")
          `CHECK(busy, 1'b0, "busy at end")
          if (!n.err) `CHECK(blank_fail, n.bf, "blank flag")
          if (!n.err) `CHECK(arr_cmd_code, n.code, "array code")
        end
      end
    end
  end

  initial begin
    int p, i;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    `CHECK(cmd_ready, 1'b1, "ready after reset")
    `CHECK(cmd_done, 1'b0, "done after reset")
    @(posedge sys_clk);
    for (p = 0; p < 2; p++) begin
      wait_idle();
      div = (p == 0) ? 0 : 1 + int'(nxt() % 4);
      nvm_clock_divider <= 8'(div);
      // Every legal code, back to back with the next one held while busy
      for (i = 0; i < 17; i++) begin
        mk(codes[i], -1, i % 2, 1 + nxt() % 40, 1 + nxt() % 4);
      end
    end
    mk(8'h00, -1, 0, 1, 1);
    mk(8'h05, -1, 0, 1, 1);
    mk(8'h11, -1, 0, 1, 0);
    mk(8'h11, -1, 0, 1, 5);
    mk(8'hFF, -1, 0, 1, 1);
    wait_idle();
    fail_en <= 1'b1;
    fail_addr <= 18'h00005;
    mk(8'h03, 5, 0, 20, 1);
    wait_idle();
    fail_addr <= 18'h00000;
    mk(8'h02, 0, 1, 1, 1);
    wait_idle();
    fail_en <= 1'b0;
    mk(8'h10, -1, 0, 30, 1);
    wait_idle();
    print_verdict();
  end
endmodule : tb_nvs_sequencer

`default_nettype wire
